// *** output_formatter.sv ***
// Parallel video output formatter with APB control registers
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module output_formatter
	import output_formatter_pkg::*;
(
	input  wire  logic        CORE_CLK,
	input  wire  logic        RST_N,
	input  wire  logic        PSEL,
	input  wire  logic        PENABLE,
	input  wire  logic        PWRITE,
	input  wire  logic [11:0] PADDR,
	input  wire  logic [31:0] PWDATA,
	output var   logic [31:0] PRDATA,
	output var   logic        PREADY,
	output var   logic        PSLVERR,
	input  wire  in_word_t    IN_WORD,
	input  wire  mode_pins_t  DETECTED_MODE,
	input  wire  logic        BUS_WIDTH_SELECT,
	input  wire  mode_pins_t  MODE_IN,
	output var   mode_pins_t  MODE_OUT,
	output var   logic [2:0]  MODE_OE_N,
	output var   logic [19:0] DOUT,
	output var   logic        DOUT_OE_N,
	output var   logic        PCLK,
	output var   logic        PCLK_OE_N
);

	typedef struct packed {
		mode_pins_t  m1;
		mode_pins_t  m2;
		mode_pins_t  m3;
		mode_pins_t  m_filt;
		logic        w1;
		logic        w2;
		logic        w3;
		logic        w_filt;
		logic        master;
		logic [31:0] words;
		logic [9:0]  upper;
		logic        half;
		logic [19:0] dout;
		logic        pclk;
		logic        pclk_pin;
		logic        oe_n;
		logic [7:0]  cnt;
		logic [7:0]  period;
		mode_pins_t  mode_out;
		logic        mode_oe_n;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} state_t;

	logic   rst_meta_reg;
	logic   rst_sync_n_reg;
	state_t st_reg;
	state_t st_next;

	// Reset asserts at once and releases two clocks later
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	mode_pins_t  mode_eff;
	fmt_t        fmt;
	logic        width20;
	logic        launch;
	logic [19:0] word;
	logic [7:0]  half_period;
	logic        access;
	logic [31:0] status;

	always_comb begin
		st_next = st_reg;
		launch  = 1'b0;
		word    = 20'h0_0000;

		// Pins come from outside: three stages, accept when the last two stages agree
		st_next.m1 = MODE_IN;
		st_next.m2 = st_reg.m1;
		st_next.m3 = st_reg.m2;
		if (st_reg.m2 == st_reg.m3) begin
			st_next.m_filt = st_reg.m3;
		end
		st_next.w1 = BUS_WIDTH_SELECT;
		st_next.w2 = st_reg.w1;
		st_next.w3 = st_reg.w2;
		if (st_reg.w2 == st_reg.w3) begin
			st_next.w_filt = st_reg.w3;
		end

		// Master uses its own detection, slave obeys the pins
		mode_eff = st_reg.master ? DETECTED_MODE : st_reg.m_filt;
		if (mode_eff.bypass_n && !mode_eff.asi) begin
			fmt = FMT_SMPTE;
		end else if (!mode_eff.bypass_n && mode_eff.asi && mode_eff.sd) begin
			fmt = FMT_ASI;
		end else if (!mode_eff.bypass_n && !mode_eff.asi
				&& !st_reg.master) begin
			fmt = FMT_THRU;
		end else begin
			fmt = FMT_NONE;
		end
		width20 = st_reg.w_filt && (fmt != FMT_ASI);

		st_next.mode_out  = DETECTED_MODE;
		st_next.mode_oe_n = !st_reg.master;
		st_next.oe_n      = 1'b0;

		if (IN_WORD.valid) begin
			case (fmt)
				FMT_SMPTE: begin
					if (!width20) begin
						launch = 1'b1;
						word   = {IN_WORD.data, 10'h000};
					end else if (IN_WORD.luma) begin
						st_next.upper = IN_WORD.data;
						st_next.half  = 1'b1;
					end else if (st_reg.half) begin
						launch       = 1'b1;
						word         = {st_reg.upper, IN_WORD.data};
						st_next.half = 1'b0;
					end
				end
				FMT_ASI: begin
					launch = 1'b1;
					word   = {IN_WORD.sync, IN_WORD.word_error_flag,
						IN_WORD.data[7:0], 10'h000};
				end
				FMT_THRU: begin
					// Pairs by arrival order only; no alignment here
					if (!width20) begin
						launch = 1'b1;
						word   = {IN_WORD.data, 10'h000};
					end else if (!st_reg.half) begin
						st_next.upper = IN_WORD.data;
						st_next.half  = 1'b1;
					end else begin
						launch       = 1'b1;
						word         = {st_reg.upper, IN_WORD.data};
						st_next.half = 1'b0;
					end
				end
				default: begin
					launch = 1'b1;
					word   = 20'h0_0000;
				end
			endcase
			if (st_reg.master && !IN_WORD.locked) begin
				word = 20'h0_0000;
			end
		end
		if (fmt != FMT_SMPTE && fmt != FMT_THRU) begin
			st_next.half = 1'b0;
		end

		// Clock period is measured from word spacing, so the rate tracks
		// the format; halving is exact only for even spacings
		half_period = st_reg.period >> 1;
		if (half_period < HALF_MIN) begin
			half_period = HALF_MIN;
		end
		if (launch) begin
			st_next.dout   = word;
			st_next.pclk   = 1'b1;
			st_next.cnt    = 8'h01;
			st_next.period = st_reg.cnt;
			st_next.words  = st_reg.words + 32'h0000_0001;
		end else begin
			if (st_reg.cnt != CNT_MAX) begin
				st_next.cnt = st_reg.cnt + 8'h01;
			end
			if (st_reg.cnt >= half_period) begin
				st_next.pclk = 1'b0;
			end
		end
		st_next.pclk_pin = st_next.pclk ^ mode_eff.sd;

		// APB: one wait state, write lands on the completing edge
		access = PSEL && PENABLE;
		status = 32'h0000_0000;
		status[STAT_PIN_ASI_BIT] = mode_eff.asi;
		status[STAT_PIN_BYP_BIT] = mode_eff.bypass_n;
		status[STAT_PIN_SD_BIT]  = mode_eff.sd;
		status[STAT_MASTER_BIT]  = st_reg.master;
		status[STAT_SMPTE_BIT]   = (fmt == FMT_SMPTE);
		status[STAT_ASI_BIT]     = (fmt == FMT_ASI);
		status[STAT_THRU_BIT]    = (fmt == FMT_THRU);
		status[STAT_WIDTH20_BIT] = width20;
		status[STAT_LOCKED_BIT]  = IN_WORD.locked;
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;
		if (access && !st_reg.pready) begin
			st_next.pready = 1'b1;
			st_next.prdata = 32'h0000_0000;
			case (PADDR)
				CTRL_OFFSET: begin
					st_next.prdata[CTRL_MASTER_BIT] = st_reg.master;
				end
				STATUS_OFFSET: begin
					st_next.prdata = status;
				end
				COUNT_OFFSET: begin
					st_next.prdata = st_reg.words;
				end
				default: begin
					st_next.pslverr = 1'b1;
				end
			endcase
		end
		if (access && st_reg.pready && PWRITE && PADDR == CTRL_OFFSET) begin
			st_next.master = PWDATA[CTRL_MASTER_BIT];
		end
	end

	// Reset value forces every output enable high: bus released
	always_ff @(posedge CORE_CLK or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			st_reg           <= '0;
			st_reg.master    <= CTRL_RESET[CTRL_MASTER_BIT];
			st_reg.m_filt    <= MODE_RESET;
			st_reg.period    <= PERIOD_RESET;
			st_reg.oe_n      <= 1'b1;
			st_reg.mode_oe_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign PRDATA    = st_reg.prdata;
	assign PREADY    = st_reg.pready;
	assign PSLVERR   = st_reg.pslverr;
	assign MODE_OUT  = st_reg.mode_out;
	assign MODE_OE_N = {3{st_reg.mode_oe_n}};
	assign DOUT      = st_reg.dout;
	assign DOUT_OE_N = st_reg.oe_n;
	assign PCLK      = st_reg.pclk_pin;
	assign PCLK_OE_N = st_reg.oe_n;

endmodule : output_formatter
`default_nettype wire

// *** output_formatter_pkg.sv ***
// Shared constants and carrier types for the parallel output formatter
package output_formatter_pkg;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] COUNT_OFFSET  = 12'h008;

	// Control register fields and reset value
	localparam int          CTRL_MASTER_BIT = 0;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

	// Status register field positions
	localparam int STAT_PIN_ASI_BIT    = 0;
	localparam int STAT_PIN_BYP_BIT    = 1;
	localparam int STAT_PIN_SD_BIT     = 2;
	localparam int STAT_MASTER_BIT     = 3;
	localparam int STAT_SMPTE_BIT      = 4;
	localparam int STAT_ASI_BIT        = 5;
	localparam int STAT_THRU_BIT       = 6;
	localparam int STAT_WIDTH20_BIT    = 7;
	localparam int STAT_LOCKED_BIT     = 8;

	// Output clock timing
	localparam logic [7:0] PERIOD_RESET = 8'h02;
	localparam logic [7:0] HALF_MIN     = 8'h01;
	localparam logic [7:0] CNT_MAX      = 8'hff;

	// Mode pins: output rate, video decode bypass, transport select
	typedef struct packed {
		logic sd;
		logic bypass_n;
		logic asi;
	} mode_pins_t;

	localparam mode_pins_t MODE_RESET = 3'h0;

	// One recovered word from the deserializer core
	typedef struct packed {
		logic       valid;
		logic       luma;
		logic       locked;
		logic       sync;
		logic       word_error_flag;
		logic [9:0] data;
	} in_word_t;

	typedef enum logic [1:0] {
		FMT_SMPTE = 2'b00,
		FMT_ASI   = 2'b01,
		FMT_THRU  = 2'b11,
		FMT_NONE  = 2'b10
	} fmt_t;

endpackage : output_formatter_pkg

// *** output_formatter_properties.sv ***
// Port checker for the parallel output formatter
`timescale 1ns/1ps
`default_nettype none
module output_formatter_properties
	import output_formatter_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PREADY,
	input wire in_word_t    IN_WORD,
	input wire mode_pins_t  DETECTED_MODE,
	input wire logic        BUS_WIDTH_SELECT,
	input wire mode_pins_t  MODE_OUT,
	input wire logic [2:0]  MODE_OE_N,
	input wire logic [19:0] DOUT,
	input wire logic        DOUT_OE_N,
	input wire logic        PCLK_OE_N
);
	logic [3:0] low_cnt;
	logic       vld, mst, lost;
	assign vld = IN_WORD.valid;
	assign mst = MODE_OE_N == 3'h0;
	assign lost = mst && vld && !IN_WORD.locked;
	// Width pin is filtered, so trust it only after a settled stretch
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			low_cnt <= 4'h0;
		else if (BUS_WIDTH_SELECT)
			low_cnt <= 4'h0;
		else if (low_cnt != 4'hf)
			low_cnt <= low_cnt + 4'h1;
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	property ten_low;
		$changed(DOUT) && low_cnt > 4'h7 |-> DOUT[9:0] == 10'h0;
	endproperty
	a_oe_drive: assert property ($rose(RST_N) |-> ##[1:4] !DOUT_OE_N)
		else $error("outputs not enabled");
	a_oe_pair: assert property (PCLK_OE_N == DOUT_OE_N)
		else $error("enables differ");
	a_launch_cause: assert property ($changed(DOUT) |-> $past(vld))
		else $error("data moved without word");
	a_ten_low: assert property (ten_low)
		else $error("lower bits not low");
	a_master_zero: assert property (lost |=> DOUT == 20'h0)
		else $error("data not forced low");
	a_mode_out: assert property (mst |-> MODE_OUT == $past(DETECTED_MODE))
		else $error("mode status wrong");
	a_mode_oe: assert property (mst || MODE_OE_N == 3'h7)
		else $error("mode enables split");
	a_ready_due: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready late");
	a_ready_one: assert property (PREADY |=> !PREADY)
		else $error("ready too long");
	c_lost: cover property (lost ##1 DOUT == 20'h0);
	c_ten: cover property ($changed(DOUT) && low_cnt > 4'h7);
	c_master: cover property ($fell(MODE_OE_N[0]));
endmodule : output_formatter_properties
bind output_formatter output_formatter_properties chk (.CORE_CLK(CORE_CLK),
	.RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
	.IN_WORD(IN_WORD), .DETECTED_MODE(DETECTED_MODE),
	.BUS_WIDTH_SELECT(BUS_WIDTH_SELECT), .MODE_OUT(MODE_OUT),
	.MODE_OE_N(MODE_OE_N), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N),
	.PCLK_OE_N(PCLK_OE_N));
`default_nettype wire

// *** sdi_parallel_output_formatter_bench.sv ***
// Directed bench for the parallel output formatter
`timescale 1ns/1ps
`default_nettype none
module sdi_parallel_output_formatter_bench
	import output_formatter_pkg::*;
;
	localparam logic [9:0]  da = 10'h2b5;
	localparam logic [9:0]  db = 10'h14a;
	localparam logic [19:0] asi_x = {2'b10, 8'ha5, 10'h0};
	logic        clk = 1'b0, rst_n = 1'b1, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, bws = 1'b0, e, pready, pslverr, doe, pclk, poe;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [19:0] dout, got;
	logic [2:0]  moe;
	in_word_t    w = '0;
	mode_pins_t  det = '0, drv = '0, pins_w, mout;
	int          n_mismatch = 0, tests_run = 0, cyc = 0;
	always #2.5 clk = ~clk;
	output_formatter dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.IN_WORD(w), .DETECTED_MODE(det), .BUS_WIDTH_SELECT(bws),
		.MODE_IN(pins_w), .MODE_OUT(mout), .MODE_OE_N(moe), .DOUT(dout),
		.DOUT_OE_N(doe), .PCLK(pclk), .PCLK_OE_N(poe));
	video_sink sink (.clk(clk), .dout(dout), .pclk(pclk), .sd(pins_w.sd),
		.drive(drv), .mode_out(mout), .oe_n(moe), .pins(pins_w), .got(got));
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [31:0] x, g);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Ready is sampled on the rising edge that completes the access
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic send(input logic [9:0] d, input logic l, lk, s, er);
		@(posedge clk);
		w <= '{1'b1, l, lk, s, er, d};
		@(posedge clk);
		w.valid <= 1'b0;
		@(negedge clk);
	endtask : send
	// Pins pass a synchroniser and filter, so give them time to settle
	task automatic mode(input mode_pins_t m, input logic wd);
		@(posedge clk);
		drv <= m;
		det <= m;
		bws <= wd;
		repeat (10) @(posedge clk);
	endtask : mode
	task automatic run(input mode_pins_t m, input logic wd,
		input logic [9:0] a, b, input logic [19:0] x);
		mode(m, wd);
		if (b != 10'h0)
			send(a, 1'b1, 1'b1, 1'b0, 1'b0);
		send(b != 10'h0 ? b : a, 1'b0, 1'b1, !a[9], a[9]);
		chk("dout", x, dout);
		chk("pclk", !m.sd, pclk);
		repeat (2) @(posedge clk);
		chk("sink", x, got);
		$display("test mode %b done", m);
	endtask : run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		#1 rst_n = 1'b0;
		repeat (20) @(posedge clk);
		chk("dout_oe_n", 1'b1, doe);
		chk("pclk_oe_n", 1'b1, poe);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
		chk("ctrl", CTRL_RESET, r);
		apb(1'b0, 12'h00c, 32'h0, r, e);
		chk("slverr", 1'b1, e);
		$display("test registers done");
		run(3'b010, 1'b0, da, 10'h0, {da, 10'h0});
		run(3'b110, 1'b0, da, 10'h0, {da, 10'h0});
		run(3'b010, 1'b1, da, db, {da, db});
		run(3'b101, 1'b1, 10'h0a5, 10'h0, asi_x);
		apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
		chk("status", 32'h125, r);
		// Four output words have been launched by the runs above
		apb(1'b0, COUNT_OFFSET, 32'h0, r, e);
		chk("count", 32'h4, r);
		run(3'b000, 1'b1, da, db, {da, db});
		run(3'b100, 1'b0, da, 10'h0, {da, 10'h0});
		apb(1'b1, CTRL_OFFSET, 32'h1, r, e);
		apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
		chk("ctrl_master", 32'h1, r);
		mode(3'b010, 1'b0);
		chk("mode_oe_n", 3'h0, moe);
		chk("mode_out", 3'b010, mout);
		send(da, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("dout", 20'h0, dout);
		send(da, 1'b0, 1'b1, 1'b0, 1'b0);
		chk("dout", {da, 10'h0}, dout);
		mode(3'b000, 1'b0);
		send(da, 1'b0, 1'b1, 1'b0, 1'b0);
		chk("dout", 20'h0, dout);
		$display("test master done");
		print_verdict();
	end
endmodule : sdi_parallel_output_formatter_bench
`default_nettype wire

// *** video_sink.sv ***
// Downstream capture and mode pin wiring beside the output formatter
`timescale 1ns/1ps
`default_nettype none
module video_sink
	import output_formatter_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [19:0] dout,
	input  wire logic        pclk,
	input  wire logic        sd,
	input  wire mode_pins_t  drive,
	input  wire mode_pins_t  mode_out,
	input  wire logic [2:0]  oe_n,
	output var  mode_pins_t  pins,
	output var  logic [19:0] got
);
	logic last;
	// An enabled device output wins; the host side drives only in slave mode
	assign pins = (mode_out & ~oe_n) | (drive & oe_n);
	// Capture on the rising edge of pclk ^ sd, the pin clock with the SD inversion undone
	always_ff @(posedge clk) begin
		if ((pclk ^ sd) && !last)
			got <= dout;
		last <= pclk ^ sd;
	end
endmodule : video_sink
`default_nettype wire
